/* File: src/aacl_counter.sv */
// Count-mode engine: gap timeout or packet count to a terminal value
`include "aacl_map.svh"

module aacl_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic qualify,
    input wire logic enable,
    input wire logic algorithm,
    input wire logic [`AACL_CNT_W-1:0] count_value,
    output logic event_pulse,
    output logic [`AACL_CNT_W-1:0] count_now
);

    aacl_pkg::aacl_tmo_state_t state_ff, nxt_state;
    logic [`AACL_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic event_ff, nxt_event;

    wire [`AACL_CNT_W-1:0] cnt_inc = cnt_ff + 11'h001;
    wire tmo_last = (cnt_ff <= 11'h001);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_event = 1'b0;
        if (!enable) begin
            nxt_state = aacl_pkg::AACL_TMO_IDLE;
            nxt_cnt = 11'h000;
        end else if (algorithm) begin
            // Time base ignored here; value 0 wraps through the full range
            nxt_state = aacl_pkg::AACL_TMO_IDLE;
            if (qualify) begin
                if (cnt_inc == count_value) begin // see R15
                    nxt_event = 1'b1;
                    nxt_cnt = 11'h000;
                end else begin
                    nxt_cnt = cnt_inc; // see R14
                end
            end
        end else if (qualify) begin
            // Reload wins over a tick in the same cycle
            nxt_state = aacl_pkg::AACL_TMO_ARMED; // see R23
            nxt_cnt = count_value; // see R12
        end else begin
            unique case (state_ff)
                aacl_pkg::AACL_TMO_IDLE: begin
                    nxt_cnt = cnt_ff;
                end
                aacl_pkg::AACL_TMO_ARMED: begin
                    if (tick && tmo_last) begin
                        nxt_event = 1'b1; // see R13
                        nxt_cnt = 11'h000;
                        nxt_state = aacl_pkg::AACL_TMO_IDLE;
                    end else if (tick) begin
                        nxt_cnt = cnt_ff - 11'h001; // see R12
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= aacl_pkg::AACL_TMO_IDLE;
            cnt_ff <= 11'h000;
            event_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            event_ff <= nxt_event;
        end
    end

    assign event_pulse = event_ff;
    assign count_now = cnt_ff;

    tmo_expire_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R13
        enable && !algorithm && !qualify && tick && state_ff == aacl_pkg::AACL_TMO_ARMED && cnt_ff == 11'h001
        |=> event_pulse && count_now == 11'h000)
        else $error("timeout did not raise event at expiry");

    tmo_down_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R12
        enable && !algorithm && !qualify && tick && state_ff == aacl_pkg::AACL_TMO_ARMED && cnt_ff > 11'h001
        |=> !event_pulse && count_now == $past(cnt_ff) - 11'h001)
        else $error("timeout counter did not decrement by one");

    inc_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R15
        enable && algorithm && qualify && cnt_inc == count_value
        |=> event_pulse && count_now == 11'h000)
        else $error("terminal count did not raise event and clear");

    inc_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
        enable && algorithm && qualify && cnt_inc != count_value |=> !event_pulse && count_now == $past(cnt_inc))
        else $error("increment mode did not count the packet");

endmodule : aacl_counter

/* File: src/aacl_map.svh */
// Offsets, field codes, reset values and timing counts of the action and count logic
`ifndef AACL_MAP_SVH
`define AACL_MAP_SVH

// Forwarding map width, entries per port, counter width
`define AACL_FWD_W 8
`define AACL_ENTRIES 16
`define AACL_CNT_W 11
`define AACL_TBL_WORDS 64
`define AACL_ADDR_W 12

// Register byte offsets
`define AACL_PORT_STAT_OFS 12'h000
`define AACL_PORT_MASK_OFS 12'h004
`define AACL_GLOB_STAT_OFS 12'h008
`define AACL_GLOB_MASK_OFS 12'h00C
`define AACL_CNT_NOW_OFS 12'h010
`define AACL_TBL_PAGE 4'h1

// Entry word positions inside one 16-byte table slot
`define AACL_WORD_ACTION 2'h0
`define AACL_WORD_MATCH 2'h1
`define AACL_WORD_MAC_LO 2'h2
`define AACL_WORD_MAC_HI 2'h3

// Count mode selection codes
`define AACL_MODE_COUNT 2'h1
`define AACL_ENSEL_COUNT 2'h0

// Reset values and bus responses
`define AACL_RST_WORD 32'h0000_0000
`define AACL_RESP_OKAY 2'h0
`define AACL_RESP_SLVERR 2'h2

// Time base: 125 MHz clock
`define AACL_CLK_PERIOD_NS 8
`define AACL_US_NS 1000
`define AACL_MS_US 1000
`define AACL_US_CYCLES (`AACL_US_NS / `AACL_CLK_PERIOD_NS)
`define AACL_MS_CYCLES_DFLT (`AACL_MS_US * `AACL_US_CYCLES)
`define AACL_PRESC_W 17

`endif

/* File: src/aacl_pkg.sv */
// Types shared by the action and count logic
`include "aacl_map.svh"

package aacl_pkg;

    typedef enum logic [1:0] {
        AACL_PM_QOS = 2'h0,
        AACL_PM_RAISE = 2'h1,
        AACL_PM_LOWER = 2'h2,
        AACL_PM_FORCE = 2'h3
    } aacl_prio_mode_t;

    typedef enum logic [1:0] {
        AACL_MAP_KEEP = 2'h0,
        AACL_MAP_OR = 2'h1,
        AACL_MAP_AND = 2'h2,
        AACL_MAP_REPLACE = 2'h3
    } aacl_map_mode_t;

    typedef enum logic {
        AACL_TMO_IDLE = 1'b0,
        AACL_TMO_ARMED = 1'b1
    } aacl_tmo_state_t;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [`AACL_FWD_W-1:0] forward;
        logic [2:0] rsvd_lo;
        logic counter_algorithm;
        logic time_base_select;
        aacl_map_mode_t map_mode;
        logic [2:0] remark_value;
        logic remark_enable;
        logic [2:0] prio;
        aacl_prio_mode_t priority_mode;
    } aacl_action_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic [1:0] match_enable_select;
        logic [1:0] match_mode;
    } aacl_match_ctl_t;

    typedef struct packed {
        logic [47:0] mac;
        logic [15:0] ethertype;
        logic [2:0] qos_prio;
        logic [2:0] pcp;
        logic [`AACL_FWD_W-1:0] lookup_map;
        logic action_hit;
        logic [3:0] action_idx;
    } aacl_pkt_in_t;

    typedef struct packed {
        logic [2:0] prio;
        logic [2:0] pcp;
        logic [`AACL_FWD_W-1:0] fwd_map;
    } aacl_pkt_out_t;

endpackage : aacl_pkg

/* File: src/aacl_top.sv */
// Access list action stage and count-mode interrupt with an AXI4-Lite register slave
//
// Overview of operation
// R1 - Priority mode 00 keeps the QoS priority
// R2 - Mode 01 takes entry priority if higher
// R3 - Mode 10 takes entry priority if lower
// R4 - Mode 11 always takes entry priority
// R5 - Remark enable overwrites PCP with remark value
// R6 - Map mode 00 keeps lookup map
// R7 - Map mode 01 ORs entry map in
// R8 - Map mode 10 ANDs entry map in
// R9 - Map mode 11 replaces lookup map
// R10 - Map bit n means port n+1
// R11 - Time base select: 0 microseconds, 1 milliseconds
// R12 - Timeout mode loads and decrements 11-bit counter
// R13 - Timeout expiry before next packet raises interrupt
// R14 - Increment mode counts matched packets, no time base
// R15 - Terminal count raises interrupt, counter clears
// R16 - Sixteen entries per port, three fields each
// R17 - Fields independent except in count mode
// R18 - Count mode is mode 01, enable 00
// R19 - Count mode qualifies on MAC and EtherType
// R20 - Only count events cause interrupts
// R21 - Per-port status and mask, plus global level
// R22 - Count value is concatenated action bits
// R23 - Each qualifying packet reloads the timeout
// R24 - Event sets status; output gated by masks
`include "aacl_map.svh"

module aacl_top #(
    parameter int MS_CYCLES = `AACL_MS_CYCLES_DFLT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`AACL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AACL_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pkt_in_valid,
    input wire aacl_pkg::aacl_pkt_in_t pkt_in,
    output logic pkt_out_valid,
    output aacl_pkg::aacl_pkt_out_t pkt_out,
    output logic irq
);

    localparam logic [`AACL_PRESC_W-1:0] US_LIM = `AACL_PRESC_W'(`AACL_US_CYCLES - 1);
    localparam logic [`AACL_PRESC_W-1:0] MS_LIM = `AACL_PRESC_W'(MS_CYCLES - 1);

    function automatic logic aacl_is_count(input logic [31:0] ctl_word);
        aacl_pkg::aacl_match_ctl_t c;
        c = ctl_word;
        return (c.match_mode == `AACL_MODE_COUNT) && (c.match_enable_select == `AACL_ENSEL_COUNT);
    endfunction : aacl_is_count

    function automatic logic aacl_in_tbl(input logic [`AACL_ADDR_W-1:0] a);
        return a[11:8] == `AACL_TBL_PAGE;
    endfunction : aacl_in_tbl

    function automatic logic aacl_mapped(input logic [`AACL_ADDR_W-1:0] a);
        return aacl_in_tbl(a) || a == `AACL_PORT_STAT_OFS || a == `AACL_PORT_MASK_OFS
            || a == `AACL_GLOB_STAT_OFS || a == `AACL_GLOB_MASK_OFS || a == `AACL_CNT_NOW_OFS;
    endfunction : aacl_mapped

    function automatic logic [31:0] aacl_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction : aacl_merge

    // Bus slave state
    logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
    logic [`AACL_ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;

    // Entry table: four words per entry
    logic [31:0] tbl_ff [`AACL_TBL_WORDS];

    // Interrupt and time base state
    logic pstat_ff, pmask_ff, gmask_ff, irq_ff;
    logic [`AACL_PRESC_W-1:0] presc_ff;

    // Packet output state
    logic pkt_out_valid_ff;
    aacl_pkg::aacl_pkt_out_t pkt_out_ff;

    // Write path
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_ff && w_ff && !bvalid_ff;
    wire wr_ok = aacl_mapped(aw_addr_ff);
    wire wr_tbl = wr_go && aacl_in_tbl(aw_addr_ff);
    wire wr_pstat = wr_go && aw_addr_ff == `AACL_PORT_STAT_OFS && w_strb_ff[0];
    wire wr_pmask = wr_go && aw_addr_ff == `AACL_PORT_MASK_OFS && w_strb_ff[0];
    wire wr_gmask = wr_go && aw_addr_ff == `AACL_GLOB_MASK_OFS && w_strb_ff[0];
    wire [5:0] wr_idx = aw_addr_ff[7:2];

    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `AACL_RESP_OKAY;
            aw_addr_ff <= 12'h000;
            w_data_ff <= `AACL_RST_WORD;
            w_strb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? `AACL_RESP_OKAY : `AACL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `AACL_TBL_WORDS; i++) begin
                tbl_ff[i] <= `AACL_RST_WORD; // see R16
            end
        end else if (wr_tbl) begin
            tbl_ff[wr_idx] <= aacl_merge(tbl_ff[wr_idx], w_data_ff, w_strb_ff);
        end
    end

    // Count entry: lowest-numbered entry configured for count mode
    logic [`AACL_ENTRIES-1:0] cm;
    logic [3:0] cnt_idx;
    logic cnt_found;

    genvar g;
    generate
        for (g = 0; g < `AACL_ENTRIES; g++) begin : g_cm
            assign cm[g] = aacl_is_count(tbl_ff[g*4+1]); // see R18
        end
    endgenerate

    always_comb begin
        cnt_idx = 4'h0;
        cnt_found = 1'b0;
        for (int i = `AACL_ENTRIES - 1; i >= 0; i--) begin
            if (cm[i]) begin
                cnt_idx = 4'(i);
                cnt_found = 1'b1;
            end
        end
    end

    // Matching and action words of the count entry work together
    aacl_pkg::aacl_action_t cnt_act;
    assign cnt_act = tbl_ff[{cnt_idx, `AACL_WORD_ACTION}]; // see R17
    wire [47:0] cnt_mac = {tbl_ff[{cnt_idx, `AACL_WORD_MAC_HI}][15:0], tbl_ff[{cnt_idx, `AACL_WORD_MAC_LO}]};
    wire [15:0] cnt_type = tbl_ff[{cnt_idx, `AACL_WORD_MAC_HI}][31:16];
    wire cnt_qualify = pkt_in_valid && cnt_found && pkt_in.mac == cnt_mac && pkt_in.ethertype == cnt_type; // see R19
    wire [`AACL_CNT_W-1:0] cnt_value = {cnt_act.priority_mode, cnt_act.prio, cnt_act.remark_enable,
                                        cnt_act.remark_value, cnt_act.map_mode}; // see R22

    // One prescaler; its limit follows the time base of the count entry
    wire [`AACL_PRESC_W-1:0] presc_lim = cnt_act.time_base_select ? MS_LIM : US_LIM; // see R11
    wire tick = presc_ff >= presc_lim;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_ff <= 17'h0_0000;
        end else begin
            presc_ff <= tick ? 17'h0_0000 : presc_ff + 17'h0_0001;
        end
    end

    wire cnt_event;
    wire [`AACL_CNT_W-1:0] cnt_now;

    aacl_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .qualify(cnt_qualify),
        .enable(cnt_found),
        .algorithm(cnt_act.counter_algorithm),
        .count_value(cnt_value),
        .event_pulse(cnt_event),
        .count_now(cnt_now)
    );

    // Status: a count event in the clearing cycle survives the clear
    wire pstat_clr = wr_pstat && w_data_ff[0];
    wire nxt_pstat = cnt_event || (pstat_ff && !pstat_clr); // see R20
    wire gstat = pstat_ff && pmask_ff; // see R21

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pstat_ff <= 1'b0;
            pmask_ff <= 1'b0;
            gmask_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            pstat_ff <= nxt_pstat; // see R24
            pmask_ff <= wr_pmask ? w_data_ff[0] : pmask_ff;
            gmask_ff <= wr_gmask ? w_data_ff[0] : gmask_ff;
            irq_ff <= gstat && gmask_ff; // see R24
        end
    end

    assign irq = irq_ff;

    // Read path
    wire [`AACL_ADDR_W-1:0] ra = s_axi_araddr;
    wire [31:0] rd_word = aacl_in_tbl(ra) ? tbl_ff[ra[7:2]]
                        : (ra == `AACL_PORT_STAT_OFS) ? {31'h0000_0000, pstat_ff}
                        : (ra == `AACL_PORT_MASK_OFS) ? {31'h0000_0000, pmask_ff}
                        : (ra == `AACL_GLOB_STAT_OFS) ? {31'h0000_0000, gstat}
                        : (ra == `AACL_GLOB_MASK_OFS) ? {31'h0000_0000, gmask_ff}
                        : (ra == `AACL_CNT_NOW_OFS) ? {21'h0_0000, cnt_now}
                        : `AACL_RST_WORD;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= `AACL_RST_WORD;
            rresp_ff <= `AACL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= aacl_mapped(ra) ? `AACL_RESP_OKAY : `AACL_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Action stage; a count entry's action word carries counter settings only
    aacl_pkg::aacl_action_t act_sel;
    assign act_sel = tbl_ff[{pkt_in.action_idx, `AACL_WORD_ACTION}];
    wire act_use = pkt_in.action_hit && !aacl_is_count(tbl_ff[{pkt_in.action_idx, `AACL_WORD_MATCH}]); // see R17
    logic [2:0] nxt_prio;
    logic [`AACL_FWD_W-1:0] nxt_map;
    wire [2:0] nxt_pcp = (act_use && act_sel.remark_enable) ? act_sel.remark_value : pkt_in.pcp; // see R5

    always_comb begin
        nxt_prio = pkt_in.qos_prio;
        if (act_use) begin
            unique case (act_sel.priority_mode)
                aacl_pkg::AACL_PM_QOS: nxt_prio = pkt_in.qos_prio; // see R1
                aacl_pkg::AACL_PM_RAISE: nxt_prio = (act_sel.prio > pkt_in.qos_prio) ? act_sel.prio
                                                                                    : pkt_in.qos_prio; // see R2
                aacl_pkg::AACL_PM_LOWER: nxt_prio = (act_sel.prio < pkt_in.qos_prio) ? act_sel.prio
                                                                                    : pkt_in.qos_prio; // see R3
                aacl_pkg::AACL_PM_FORCE: nxt_prio = act_sel.prio; // see R4
            endcase
        end
    end

    // Bit n of each map is switch port n+1
    always_comb begin
        nxt_map = pkt_in.lookup_map; // see R10
        if (act_use) begin
            unique case (act_sel.map_mode)
                aacl_pkg::AACL_MAP_KEEP: nxt_map = pkt_in.lookup_map; // see R6
                aacl_pkg::AACL_MAP_OR: nxt_map = pkt_in.lookup_map | act_sel.forward; // see R7
                aacl_pkg::AACL_MAP_AND: nxt_map = pkt_in.lookup_map & act_sel.forward; // see R8
                aacl_pkg::AACL_MAP_REPLACE: nxt_map = act_sel.forward; // see R9
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pkt_out_valid_ff <= 1'b0;
            pkt_out_ff <= '0;
        end else begin
            pkt_out_valid_ff <= pkt_in_valid;
            if (pkt_in_valid) begin
                pkt_out_ff <= '{prio: nxt_prio, pcp: nxt_pcp, fwd_map: nxt_map};
            end
        end
    end

    assign pkt_out_valid = pkt_out_valid_ff;
    assign pkt_out = pkt_out_ff;

    wire act_in = pkt_in_valid && act_use;

    prio_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
        act_in && act_sel.priority_mode == aacl_pkg::AACL_PM_QOS |=> pkt_out.prio == $past(pkt_in.qos_prio))
        else $error("priority changed in QoS mode");

    prio_raise_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
        act_in && act_sel.priority_mode == aacl_pkg::AACL_PM_RAISE && act_sel.prio <= pkt_in.qos_prio
        |=> pkt_out.prio == $past(pkt_in.qos_prio))
        else $error("raise mode lowered or replaced priority");

    prio_lower_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
        act_in && act_sel.priority_mode == aacl_pkg::AACL_PM_LOWER && act_sel.prio < pkt_in.qos_prio
        |=> pkt_out.prio == $past(act_sel.prio))
        else $error("lower mode did not take smaller priority");

    prio_force_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
        act_in && act_sel.priority_mode == aacl_pkg::AACL_PM_FORCE |=> pkt_out.prio == $past(act_sel.prio))
        else $error("force mode did not take entry priority");

    pcp_remark_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
        pkt_in_valid |=> pkt_out.pcp == ($past(act_use && act_sel.remark_enable) ? $past(act_sel.remark_value)
                                                                              : $past(pkt_in.pcp)))
        else $error("PCP remark wrong");

    map_and_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
        act_in && act_sel.map_mode == aacl_pkg::AACL_MAP_AND
        |=> pkt_out.fwd_map == ($past(pkt_in.lookup_map) & $past(act_sel.forward)))
        else $error("AND map mode wrong");

    map_repl_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
        act_in && act_sel.map_mode == aacl_pkg::AACL_MAP_REPLACE |=> pkt_out.fwd_map == $past(act_sel.forward))
        else $error("replace map mode wrong");

    sequence s_event_unmasked;
        cnt_event && pmask_ff && gmask_ff && !wr_pmask && !wr_gmask;
    endsequence

    sequence s_status_then_irq;
        pstat_ff ##1 irq;
    endsequence

    event_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R24
        s_event_unmasked |=> s_status_then_irq)
        else $error("unmasked count event did not reach interrupt");

    irq_masked_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R21
        !pmask_ff || !gmask_ff |=> !irq)
        else $error("interrupt asserted while masked");

    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R24
        cnt_event && pstat_clr |=> pstat_ff)
        else $error("count event lost under clear");

endmodule : aacl_top

/* File: verif/aacl_pipe_model.sv */
// Ingress pipeline stand-in that launches one packet per request
module aacl_pipe_model (
    input wire logic aclk,
    input wire logic send,
    input wire aacl_pkg::aacl_pkt_in_t req,
    output logic pkt_in_valid,
    output aacl_pkg::aacl_pkt_in_t pkt_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pkt_in_valid = 1'h0;
        pkt_in = '0;
    end
    // Idle payload toggles so a stale packet never looks valid
    always @(posedge aclk) begin
        pkt_in_valid <= send;
        pkt_in <= send ? req : ~pkt_in;
    end
endmodule : aacl_pipe_model

/* File: verif/acl_action_and_count_logic_bench.sv */
// Self-checking bench for the action stage and count interrupt
module acl_action_and_count_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, send = 1'h0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic awr, wr, bv, arr, rv, pov, irq, pv;
    logic [1:0] br, rr;
    aacl_pkg::aacl_pkt_in_t req = '0, pin;
    aacl_pkg::aacl_pkt_out_t po;
    int n_errors = 0, checks_done = 0, act[16], cm[16];
    initial forever #4 aclk = ~aclk;
    aacl_top #(.MS_CYCLES(20)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .pkt_in_valid(pv), .pkt_in(pin), .pkt_out_valid(pov), .pkt_out(po), .irq(irq));
    aacl_pipe_model u_pipe (.aclk(aclk), .send(send), .req(req), .pkt_in_valid(pv), .pkt_in(pin));
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk_reg
    task automatic chk_pkt(input logic [13:0] e, input logic [13:0] g);
        chk_reg("pkt_out", {18'h0_0000, e}, {18'h0_0000, g});
    endtask : chk_pkt
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic ak, wk, bk;
        logic [1:0] r;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do begin
            @(negedge aclk);
            ak = awv && awr;
            wk = wv && wr;
            bk = bv;
            r = br;
            @(posedge aclk);
            if (ak) awv <= 1'h0;
            if (wk) wv <= 1'h0;
        end while (!bk);
        bry <= 1'h0;
        // Table page and the five control words answer OKAY, the rest SLVERR
        chk_reg("bresp", (a[11:8] == 4'h1 || a < 12'h014) ? 0 : 2, {30'h0, r});
    endtask : wr_reg
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re);
        logic ak, dk;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(negedge aclk);
            ak = arv && arr;
            dk = rv;
            d = rd;
            r = rr;
            @(posedge aclk);
            if (ak) arv <= 1'h0;
        end while (!dk);
        rry <= 1'h0;
        chk_reg("rdata", e, d);
        chk_reg("rresp", {30'h0, re}, {30'h0, r});
    endtask : rd_chk
    function automatic logic [13:0] mdl(input aacl_pkg::aacl_pkt_in_t p);
        int w;
        logic [2:0] pr, pc;
        logic [7:0] m;
        w = act[p.action_idx];
        pr = p.qos_prio;
        pc = p.pcp;
        m = p.lookup_map;
        // Count-mode entries carry counter settings, not actions
        if (p.action_hit && cm[p.action_idx] == 0) begin
            case (w[1:0])
                2'h1: pr = w[4:2] > pr ? w[4:2] : pr;
                2'h2: pr = w[4:2] < pr ? w[4:2] : pr;
                2'h3: pr = w[4:2];
                default: ;
            endcase
            if (w[5]) pc = w[8:6];
            case (w[10:9])
                2'h1: m = m | w[23:16];
                2'h2: m = m & w[23:16];
                2'h3: m = w[23:16];
                default: ;
            endcase
        end
        return {pr, pc, m};
    endfunction : mdl
    task automatic pkt(input aacl_pkg::aacl_pkt_in_t p);
        @(posedge aclk);
        send <= 1'h1;
        req <= p;
        @(posedge aclk);
        send <= 1'h0;
        repeat (2) @(negedge aclk);
        chk_reg("pkt_out_valid", 1, pov);
        chk_pkt(mdl(p), po);
    endtask : pkt
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        aacl_pkg::aacl_pkt_in_t p;
        int w, e;
        void'($urandom(8));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        wr_reg(12'hFFC, 32'hFFFF_FFFF);
        rd_chk(12'h004, 32'h0000_0000, 2'h0);
        rd_chk(12'hFFC, 32'h0000_0000, 2'h2);
        for (int i = 0; i < 48; i++) begin
            e = $urandom % 16;
            w = ($urandom & 32'h00FF_19FC) | (i % 4) | ((i / 4 % 4) << 9);
            wr_reg(12'(256 + e * 16), w);
            act[e] = w;
            p = 83'({$urandom, $urandom, $urandom});
            p.action_idx = e[3:0];
            p.action_hit = i % 6 != 0;
            pkt(p);
        end
        chk_reg("irq", 0, irq);
        cm[3] = 1;
        wr_reg(12'h134, 32'h0000_0001);
        wr_reg(12'h138, 32'h89AB_CDEF);
        wr_reg(12'h13C, 32'h88F7_0123);
        wr_reg(12'h130, 32'h0000_1600);
        wr_reg(12'h004, 32'h0000_0001);
        wr_reg(12'h00C, 32'h0000_0001);
        p = {48'h0123_89AB_CDEF, 16'h88F6, 19'h0_0013};
        for (int i = 1; i <= 3; i++) begin
            pkt(p);
            p.ethertype = 16'h88F7;
            pkt(p);
            p.ethertype = 16'h88F6;
            repeat (4) @(negedge aclk);
            chk_reg("irq", i == 3, irq);
        end
        rd_chk(12'h008, 32'h0000_0001, 2'h0);
        rd_chk(12'h010, 32'h0000_0000, 2'h0);
        wr_reg(12'h000, 32'h0000_0001);
        repeat (3) @(negedge aclk);
        chk_reg("irq", 0, irq);
        wr_reg(12'h130, 32'h0000_0C00);
        p.ethertype = 16'h88F7;
        for (int i = 0; i < 4; i++) begin
            pkt(p);
            repeat (12) @(negedge aclk);
        end
        chk_reg("irq", 0, irq);
        repeat (45) @(negedge aclk);
        chk_reg("irq", 1, irq);
        wr_reg(12'h004, 32'h0000_0000);
        repeat (3) @(negedge aclk);
        chk_reg("irq", 0, irq);
        end_sim;
    end
    // Whole run is well under a thousand cycles; this only catches a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        end_sim;
    end
endmodule : acl_action_and_count_logic_bench
